// ===== hdl/cpfu_pkg.sv
// Purpose: constants, types and helpers for the cpu program flow unit
// Assumes: registers reached over avalon-mm, byte addressed, one word each
// Notes: an instruction is issued by writing the instruction word register
// What this block does
// - shift left, shift right, rotate any 8-bit register by encoded count
// - compare subtracts immediate from register, flags show the difference
// - bit test ands register with immediate, flags show the and result
// - compare and bit test write no register, only the alu flags
// - relative jump adds sign-extended 8-bit immediate to next-instruction pc
// - register relative jump adds sign-extended source register to pc
// - absolute jump loads a 16-bit target into the pc
// - indexed absolute jump loads the pc from the 16-bit index pair
// - conditional relative jump adds displacement when selected flag matches state
// - selector picks alu flags 0-3 or link status flags 4-7
// - condition aliases are the conditional jump with fixed flag and state
// - conditional absolute jump tests a register bit, loads target on match
// - rotate-mask jump rotates a copy right, source stays, copy is displacement
// - rotate-mask jump always clears displacement bit zero
// - rotate-mask jump clears m top bits, sign-extends, adds to pc
// - relative call adds displacement, absolute call loads 16-bit target
// - a call pushes next pc, irq enable, alu flags, bank selection
// - address stack holds twelve entries used by calls and returns
// - return pops pc, optionally restores irq enable, flags and bank
// - conditional call pushes and loads target only when register bit matches
`default_nettype none
package cpfu_pkg;
    localparam logic [7:0]  OFS_INSTR   = 8'h00;
    localparam logic [7:0]  OFS_OPND    = 8'h04;
    localparam logic [7:0]  OFS_PC      = 8'h08;
    localparam logic [7:0]  OFS_FLAGS   = 8'h0c;
    localparam logic [7:0]  OFS_STAT    = 8'h10;
    localparam logic [7:0]  OFS_INDEX   = 8'h14;
    localparam logic [2:0]  OFS_RF_HI   = 3'h1;
    localparam int unsigned F_OP_LSB    = 0;
    localparam int unsigned F_RS_LSB    = 4;
    localparam int unsigned F_B_LSB     = 7;
    localparam int unsigned F_M_LSB     = 10;
    localparam int unsigned F_S_BIT     = 13;
    localparam int unsigned FL_IRQ_BIT  = 4;
    localparam int unsigned FL_BANK_LSB = 5;
    localparam int unsigned ST_OVF_BIT  = 4;
    localparam int unsigned ST_UNF_BIT  = 5;
    localparam int unsigned ST_LINK_LSB = 8;
    localparam logic [15:0] PC_RST      = 16'h0000;
    localparam logic [3:0]  ALU_RST     = 4'h0;
    localparam logic [1:0]  BANK_RST    = 2'h0;
    localparam logic        IRQ_RST     = 1'b0;
    localparam logic [3:0]  STACK_DEPTH = 4'hc;
    localparam int unsigned ENTRY_W     = 23;
    localparam int unsigned FLG_NIL     = 0;
    localparam int unsigned FLG_SPILL   = 1;
    localparam int unsigned FLG_RANGE   = 2;
    localparam int unsigned FLG_MSB     = 3;

    typedef enum logic [3:0] {
        OP_SHL  = 4'h0, OP_SHR  = 4'h1, OP_ROR  = 4'h2, OP_RMJ  = 4'h3,
        OP_CMP  = 4'h4, OP_BIT  = 4'h5, OP_JRI  = 4'h6, OP_JRR  = 4'h7,
        OP_JAA  = 4'h8, OP_JAX  = 4'h9, OP_JRC  = 4'ha, OP_JAB  = 4'hb,
        OP_CLR  = 4'hc, OP_CLA  = 4'hd, OP_CLB  = 4'he, OP_RET  = 4'hf
    } cpfu_op_type;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_ACK  = 2'h1,
        BUS_EXEC = 2'h3
    } cpfu_bus_type;

    function automatic logic [15:0] sext8(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction : sext8

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16
endpackage : cpfu_pkg
`default_nettype wire

// ===== hdl/cpfu_shifter.sv
// Purpose: barrel shift, rotate and rotate-mask of one register byte
// Assumes: purely combinational, count and mask taken from the instruction
// Notes: mode 3 builds the jump table displacement
`timescale 1ns/1ns
`default_nettype none
module cpfu_shifter (
    input  wire logic [7:0] value_in,
    input  wire logic [2:0] count_in,
    input  wire logic [2:0] mask_in,
    input  wire logic [1:0] mode_in,
    output logic      [7:0] result_out
);
    logic [15:0] dbl;
    logic [7:0]  rot;
    logic [7:0]  keep;

    assign dbl  = {value_in, value_in} >> count_in;
    assign rot  = dbl[7:0];
    // top m bits and bit zero cleared
    assign keep = (8'hff >> mask_in) & 8'hfe;

    always_comb begin
        case (mode_in)
            2'h0:    result_out = value_in << count_in;
            2'h1:    result_out = value_in >> count_in;
            2'h2:    result_out = rot;
            default: result_out = rot & keep;
        endcase
    end
endmodule : cpfu_shifter
`default_nettype wire

// ===== hdl/cpfu_stack.sv
// Purpose: twelve-entry address stack for calls and returns
// Assumes: push and pop never together; caller checks full and empty
// Notes: entry holds pc, irq enable, alu flags and bank selection
`timescale 1ns/1ns
`default_nettype none
module cpfu_stack (
    input  wire logic                          clk_in,
    input  wire logic                          rstn_in,
    input  wire logic                          push_in,
    input  wire logic                          pop_in,
    input  wire logic [cpfu_pkg::ENTRY_W-1:0]  data_in,
    output logic      [cpfu_pkg::ENTRY_W-1:0]  top_out,
    output logic      [3:0]                    depth_out,
    output logic                               full_out,
    output logic                               empty_out
);
    logic [cpfu_pkg::ENTRY_W-1:0] mem_r [cpfu_pkg::STACK_DEPTH];
    logic [3:0]                   depth_r;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            depth_r <= 4'h0;
        end else if (push_in && !full_out) begin
            depth_r <= depth_r + 4'h1;
        end else if (pop_in && !empty_out) begin
            depth_r <= depth_r - 4'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (push_in && !full_out) begin
            mem_r[depth_r] <= data_in;
        end
    end

    assign top_out   = empty_out ? '0 : mem_r[depth_r - 4'h1];
    assign depth_out = depth_r;
    assign full_out  = (depth_r == cpfu_pkg::STACK_DEPTH);
    assign empty_out = (depth_r == 4'h0);
endmodule : cpfu_stack
`default_nettype wire

// ===== hdl/cpfu_top.sv
// Purpose: shift, compare and program flow execution of an 8-bit cpu
// Assumes: link status pins come from the transceiver clock domain
// Notes: pc already holds the next instruction address when one is issued
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns
`default_nettype none
module cpfu_top (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    input  wire logic [3:0]  link_status_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    output logic      [15:0] pc_out,
    output logic      [1:0]  bank_out,
    output logic             irq_enable_out
);
    cpfu_pkg::cpfu_bus_type bus_r;
    logic [31:0]            rdata_r;
    logic                   wait_r;
    logic [15:0]            instr_r;
    logic [15:0]            opnd_r;
    logic [15:0]            pc_r;
    logic [15:0]            index_r;
    logic [3:0]             alu_r;
    logic                   irq_r;
    logic [1:0]             bank_r;
    logic [7:0]             rf_r [8];
    logic                   ovf_r;
    logic                   unf_r;
    logic [3:0]             link_s1_r;
    logic [3:0]             link_s2_r;

    cpfu_pkg::cpfu_op_type  op;
    logic [7:0]             aw;
    logic [31:0]            rd_word;
    logic                   wr_go;
    logic                   exec;
    logic [2:0]             rs;
    logic [2:0]             bsel;
    logic [2:0]             msel;
    logic                   want;
    logic [7:0]             src;
    logic [7:0]             imm;
    logic [7:0]             shf;
    logic [7:0]             flag_vec;
    logic                   hit_rel;
    logic                   hit_bit;
    logic                   is_call;
    logic                   call_hit;
    logic                   do_push;
    logic                   do_pop;
    logic [8:0]             diff;
    logic [7:0]             andv;
    logic [15:0]            pc_nxt;
    logic [3:0]             alu_nxt;
    logic [cpfu_pkg::ENTRY_W-1:0] top;
    logic [3:0]             depth;
    logic                   full;
    logic                   empty;

    assign op       = cpfu_pkg::cpfu_op_type'(instr_r[cpfu_pkg::F_OP_LSB +: 4]);
    assign rs       = instr_r[cpfu_pkg::F_RS_LSB +: 3];
    assign bsel     = instr_r[cpfu_pkg::F_B_LSB +: 3];
    assign msel     = instr_r[cpfu_pkg::F_M_LSB +: 3];
    assign want     = instr_r[cpfu_pkg::F_S_BIT];
    assign src      = rf_r[rs];
    assign imm      = opnd_r[7:0];
    assign aw       = {avs_address_in[7:2], 2'h0};
    assign wr_go    = (bus_r == cpfu_pkg::BUS_ACK) && avs_write_in;
    assign exec     = (bus_r == cpfu_pkg::BUS_EXEC);

    // link status flags sit above the four alu flags
    assign flag_vec = {link_s2_r, alu_r};
    assign hit_rel  = (flag_vec[bsel] == want);
    assign hit_bit  = (src[bsel] == want);
    assign is_call  = (op == cpfu_pkg::OP_CLR) || (op == cpfu_pkg::OP_CLA)
                   || (op == cpfu_pkg::OP_CLB);
    assign call_hit = (op != cpfu_pkg::OP_CLB) || hit_bit;
    // a call onto a full stack is refused and flagged
    assign do_push  = exec && is_call && call_hit && !full;
    assign do_pop   = exec && (op == cpfu_pkg::OP_RET) && !empty;
    assign diff     = {1'b0, src} - {1'b0, imm};
    assign andv     = src & imm;

    cpfu_shifter u_shifter (
        .value_in   (src),
        .count_in   (bsel),
        .mask_in    (msel),
        .mode_in    (instr_r[1:0]),
        .result_out (shf)
    );

    cpfu_stack u_stack (
        .clk_in    (clk_in),
        .rstn_in   (rstn_in),
        .push_in   (do_push),
        .pop_in    (do_pop),
        .data_in   ({pc_r, irq_r, alu_r, bank_r}),
        .top_out   (top),
        .depth_out (depth),
        .full_out  (full),
        .empty_out (empty)
    );

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link_s1_r <= 4'h0;
            link_s2_r <= 4'h0;
        end else begin
            link_s1_r <= link_status_in;
            link_s2_r <= link_s1_r;
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (aw)
            cpfu_pkg::OFS_INSTR: rd_word = {16'h0000, instr_r};
            cpfu_pkg::OFS_OPND:  rd_word = {16'h0000, opnd_r};
            cpfu_pkg::OFS_PC:    rd_word = {16'h0000, pc_r};
            cpfu_pkg::OFS_FLAGS: rd_word = {25'h0000000, bank_r, irq_r, alu_r};
            cpfu_pkg::OFS_STAT:  rd_word = {20'h00000, link_s2_r, 2'h0,
                                            unf_r, ovf_r, depth};
            cpfu_pkg::OFS_INDEX: rd_word = {16'h0000, index_r};
            default: begin
                if (aw[7:5] == cpfu_pkg::OFS_RF_HI) begin
                    rd_word = {24'h000000, rf_r[aw[4:2]]};
                end
            end
        endcase
    end

    // idle -> ack (waitrequest low one cycle) -> exec after an issue
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_r   <= cpfu_pkg::BUS_IDLE;
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            case (bus_r)
                cpfu_pkg::BUS_IDLE: begin
                    if (avs_read_in || avs_write_in) begin
                        bus_r   <= cpfu_pkg::BUS_ACK;
                        wait_r  <= 1'b0;
                        rdata_r <= avs_read_in ? rd_word : 32'h0000_0000;
                    end
                end
                cpfu_pkg::BUS_ACK: begin
                    wait_r <= 1'b1;
                    if (wr_go && aw == cpfu_pkg::OFS_INSTR) begin
                        bus_r <= cpfu_pkg::BUS_EXEC;
                    end else begin
                        bus_r <= cpfu_pkg::BUS_IDLE;
                    end
                end
                default: begin
                    bus_r  <= cpfu_pkg::BUS_IDLE;
                    wait_r <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            instr_r <= 16'h0000;
            opnd_r  <= 16'h0000;
            index_r <= 16'h0000;
        end else if (wr_go) begin
            if (aw == cpfu_pkg::OFS_INSTR) begin
                instr_r <= cpfu_pkg::merge16(instr_r, avs_writedata_in,
                                             avs_byteenable_in);
            end
            if (aw == cpfu_pkg::OFS_OPND) begin
                opnd_r <= cpfu_pkg::merge16(opnd_r, avs_writedata_in,
                                            avs_byteenable_in);
            end
            if (aw == cpfu_pkg::OFS_INDEX) begin
                index_r <= cpfu_pkg::merge16(index_r, avs_writedata_in,
                                             avs_byteenable_in);
            end
        end
    end

    always_comb begin
        pc_nxt = pc_r;
        case (op)
            cpfu_pkg::OP_JRI: pc_nxt = pc_r + cpfu_pkg::sext8(imm);
            cpfu_pkg::OP_JRR: pc_nxt = pc_r + cpfu_pkg::sext8(src);
            cpfu_pkg::OP_JAA: pc_nxt = opnd_r;
            cpfu_pkg::OP_JAX: pc_nxt = index_r;
            cpfu_pkg::OP_JRC: begin
                if (hit_rel) begin
                    pc_nxt = pc_r + cpfu_pkg::sext8(imm);
                end
            end
            cpfu_pkg::OP_JAB: begin
                if (hit_bit) begin
                    pc_nxt = opnd_r;
                end
            end
            cpfu_pkg::OP_RMJ: pc_nxt = pc_r + cpfu_pkg::sext8(shf);
            cpfu_pkg::OP_CLR: begin
                if (do_push) begin
                    pc_nxt = pc_r + cpfu_pkg::sext8(imm);
                end
            end
            cpfu_pkg::OP_CLA, cpfu_pkg::OP_CLB: begin
                if (do_push) begin
                    pc_nxt = opnd_r;
                end
            end
            cpfu_pkg::OP_RET: begin
                if (do_pop) begin
                    pc_nxt = top[cpfu_pkg::ENTRY_W-1 -: 16];
                end
            end
            default: pc_nxt = pc_r;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pc_r <= cpfu_pkg::PC_RST;
        end else if (wr_go && aw == cpfu_pkg::OFS_PC) begin
            pc_r <= cpfu_pkg::merge16(pc_r, avs_writedata_in, avs_byteenable_in);
        end else if (exec) begin
            pc_r <= pc_nxt;
        end
    end

    always_comb begin
        alu_nxt = alu_r;
        if (op == cpfu_pkg::OP_CMP) begin
            alu_nxt[cpfu_pkg::FLG_NIL]   = (diff[7:0] == 8'h00);
            alu_nxt[cpfu_pkg::FLG_SPILL] = diff[8];
            alu_nxt[cpfu_pkg::FLG_RANGE] = (src[7] ^ imm[7]) & (src[7] ^ diff[7]);
            alu_nxt[cpfu_pkg::FLG_MSB]   = diff[7];
        end else if (op == cpfu_pkg::OP_BIT) begin
            alu_nxt[cpfu_pkg::FLG_NIL] = (andv == 8'h00);
            alu_nxt[cpfu_pkg::FLG_MSB] = andv[7];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            alu_r  <= cpfu_pkg::ALU_RST;
            irq_r  <= cpfu_pkg::IRQ_RST;
            bank_r <= cpfu_pkg::BANK_RST;
        end else if (wr_go && aw == cpfu_pkg::OFS_FLAGS && avs_byteenable_in[0]) begin
            alu_r  <= avs_writedata_in[3:0];
            irq_r  <= avs_writedata_in[cpfu_pkg::FL_IRQ_BIT];
            bank_r <= avs_writedata_in[cpfu_pkg::FL_BANK_LSB +: 2];
        end else if (do_pop && want) begin
            alu_r  <= top[5:2];
            irq_r  <= top[6];
            bank_r <= top[1:0];
        end else if (exec) begin
            alu_r <= alu_nxt;
        end
    end

    // compare and bit test never reach this file of registers
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < 8; i++) begin
                rf_r[i] <= 8'h00;
            end
        end else if (wr_go && aw[7:5] == cpfu_pkg::OFS_RF_HI && avs_byteenable_in[0]) begin
            rf_r[aw[4:2]] <= avs_writedata_in[7:0];
        end else if (exec && op < cpfu_pkg::OP_RMJ) begin
            rf_r[rs] <= shf;
        end
    end

    // sticky stack errors, write one to clear, a new error wins
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ovf_r <= 1'b0;
            unf_r <= 1'b0;
        end else begin
            if (exec && is_call && call_hit && full) begin
                ovf_r <= 1'b1;
            end else if (wr_go && aw == cpfu_pkg::OFS_STAT
                         && avs_writedata_in[cpfu_pkg::ST_OVF_BIT]) begin
                ovf_r <= 1'b0;
            end
            if (exec && op == cpfu_pkg::OP_RET && empty) begin
                unf_r <= 1'b1;
            end else if (wr_go && aw == cpfu_pkg::OFS_STAT
                         && avs_writedata_in[cpfu_pkg::ST_UNF_BIT]) begin
                unf_r <= 1'b0;
            end
        end
    end

    assign avs_readdata_out    = rdata_r;
    assign avs_waitrequest_out = wait_r;
    assign pc_out              = pc_r;
    assign bank_out            = bank_r;
    assign irq_enable_out      = irq_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    cmp_nil_a: assert property (exec && op == cpfu_pkg::OP_CMP
        |=> alu_r[cpfu_pkg::FLG_NIL] == ($past(src) == $past(imm)))
        else $error("compare zero flag wrong");
    cmp_keep_a: assert property (exec && (op == cpfu_pkg::OP_CMP
        || op == cpfu_pkg::OP_BIT) |=> $stable(rf_r[rs]) && $stable(pc_r))
        else $error("compare or bit test changed state");
    bit_nil_a: assert property (exec && op == cpfu_pkg::OP_BIT
        |=> alu_r[cpfu_pkg::FLG_NIL] == (($past(src) & $past(imm)) == 8'h00))
        else $error("bit test zero flag wrong");
    jump_rel_a: assert property (exec && op == cpfu_pkg::OP_JRI
        |=> pc_r == $past(pc_r) + {{8{$past(imm[7])}}, $past(imm)})
        else $error("relative jump target wrong");
    jump_abs_a: assert property (exec && op == cpfu_pkg::OP_JAA
        |=> pc_r == $past(opnd_r))
        else $error("absolute jump target wrong");
    jump_idx_a: assert property (exec && op == cpfu_pkg::OP_JAX
        |=> pc_r == $past(index_r))
        else $error("indexed jump target wrong");
    cond_miss_a: assert property (exec && ((op == cpfu_pkg::OP_JRC && !hit_rel)
        || (op == cpfu_pkg::OP_JAB && !hit_bit) || (op == cpfu_pkg::OP_CLB && !hit_bit))
        |=> $stable(pc_r) && $stable(depth) && $stable(alu_r))
        else $error("false condition changed state");
    rmj_even_a: assert property (exec && op == cpfu_pkg::OP_RMJ
        |=> pc_r[0] == $past(pc_r[0]) && $stable(rf_r[rs]))
        else $error("rotate mask jump odd or source changed");
    call_push_a: assert property (do_push
        |=> depth == $past(depth) + 4'h1 && top[22:7] == $past(pc_r))
        else $error("call push wrong");
    stack_max_a: assert property (depth <= cpfu_pkg::STACK_DEPTH)
        else $error("stack deeper than twelve");
    bus_ack_a: assert property ($rose(bus_r == cpfu_pkg::BUS_ACK)
        |-> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("waitrequest not a single low cycle");

    call_seen_c: cover property (do_push ##[1:20] do_pop);
    rmj_seen_c: cover property (exec && op == cpfu_pkg::OP_RMJ);
    miss_seen_c: cover property (exec && op == cpfu_pkg::OP_JRC && !hit_rel);
    full_seen_c: cover property (full && exec && is_call);
endmodule : cpfu_top
`default_nettype wire

// ===== dv/cpfu_tb.sv
// Purpose: self-checking bench for the cpu program flow unit
// Assumes: one idle cycle between bus accesses, link flags settle in 4 cycles
// Notes: each read queues its expected word, the monitor checks it when waitrequest drops
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        clk_in = 0, rstn_in = 0, avs_read_in = 0, avs_write_in = 0, s;
    logic [7:0]  avs_address_in = 0, v, n, r;
    logic [31:0] avs_writedata_in = 0, avs_readdata_out;
    logic [3:0]  avs_byteenable_in = 4'hf, link_status_in = 0, lk = 0, op, e4;
    logic        avs_waitrequest_out, irq_enable_out;
    logic [15:0] pc_out, pc, x;
    logic [1:0]  bank_out;
    logic [6:0]  fl, e7;
    logic [2:0]  b;
    logic [8:0]  d;
    logic [39:0] q[$];
    logic [22:0] stk[$];
    int          errors = 0, tests_run = 0, cyc = 0, seed = 18, dep = 0, i;
    logic        ovf = 0, unf = 0;

    cpfu_top dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .link_status_in(link_status_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .pc_out(pc_out), .bank_out(bank_out),
        .irq_enable_out(irq_enable_out));

    initial forever #2 clk_in = ~clk_in;

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] a, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value reg %h expected %h seen %h", a, exp, seen);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dt);
        avs_address_in   <= a;
        avs_writedata_in <= dt;
        avs_write_in     <= w;
        avs_read_in      <= !w;
        @(posedge clk_in);
        while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
        avs_write_in <= 0;
        avs_read_in  <= 0;
        @(posedge clk_in);
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        q.push_back({a, exp});
        bus(0, a, 0);
    endtask : rd

    task automatic ex(input logic [3:0] o, input logic [2:0] rs, input logic [2:0] bb,
                      input logic [2:0] m, input logic ss);
        bus(1, cpfu_pkg::OFS_INSTR, {18'h0, ss, m, bb, rs, o});
    endtask : ex

    function automatic logic [7:0] rf(input logic [2:0] k);
        return {cpfu_pkg::OFS_RF_HI, k, 2'b00};
    endfunction : rf

    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            test_done();
        end
    end

    // read data is taken only at the edge where waitrequest is low
    always @(posedge clk_in) if (avs_read_in && avs_waitrequest_out === 1'b0) begin
        if (q.size() == 0) chk(8'hff, avs_readdata_out, 32'hffff_ffff);
        else begin
            chk(q[0][39:32], avs_readdata_out, q[0][31:0]);
            void'(q.pop_front());
        end
    end

    initial begin
        repeat (5) @(posedge clk_in);
        rstn_in <= 1;
        @(posedge clk_in);
        rd(cpfu_pkg::OFS_PC, 0);
        rd(cpfu_pkg::OFS_STAT, 0);
        rd(8'hfc, 0);
        for (i = 0; i < 8; i++) begin
            pc = $random(seed);
            x = $random(seed);
            if (i < 2) x[7:0] = i ? 8'h7f : 8'h80;
            bus(1, cpfu_pkg::OFS_PC, pc);
            bus(1, cpfu_pkg::OFS_OPND, x);
            bus(1, cpfu_pkg::OFS_INDEX, ~x);
            bus(1, rf(5), x[7:0]);
            ex(cpfu_pkg::OP_JRI + i[1:0], 5, 0, 0, 0);
            rd(cpfu_pkg::OFS_PC,
               16'(i[1] ? (i[0] ? ~x : x) : pc + {{8{x[7]}}, x[7:0]}));
        end
        $display("test jumps done");
        for (i = 0; i < 12; i++) begin
            v = $random(seed);
            b = $random(seed);
            bus(1, rf(1), v);
            ex(cpfu_pkg::OP_SHL + i % 3, 1, b, 0, 0);
            rd(rf(1), 8'(i % 3 == 0 ? v << b : i % 3 == 1 ? v >> b
                         : (v >> b) | (v << (8 - b))));
        end
        $display("test shifts done");
        for (i = 0; i < 8; i++) begin
            fl = $random(seed);
            r = $random(seed);
            n = i == 0 ? r : $random(seed);
            bus(1, cpfu_pkg::OFS_FLAGS, fl);
            bus(1, rf(2), r);
            bus(1, cpfu_pkg::OFS_OPND, n);
            ex(i[0] ? cpfu_pkg::OP_BIT : cpfu_pkg::OP_CMP, 2, 0, 0, 0);
            d = {1'b0, r} - {1'b0, n};
            v = r & n;
            e4 = i[0] ? {v[7], fl[2:1], v == 0} : {d[7], (r[7] ^ n[7]) & (d[7] ^ r[7]), d[8], d[7:0] == 0};
            rd(cpfu_pkg::OFS_FLAGS, {fl[6:4], e4});
            rd(rf(2), r);
        end
        $display("test compare done");
        for (i = 0; i < 16; i++) begin
            fl = $random(seed);
            lk = $random(seed);
            n = $random(seed);
            s = $random(seed);
            link_status_in <= lk;
            repeat (4) @(posedge clk_in);
            bus(1, cpfu_pkg::OFS_FLAGS, fl);
            bus(1, cpfu_pkg::OFS_PC, 16'h4000);
            bus(1, cpfu_pkg::OFS_OPND, n);
            ex(cpfu_pkg::OP_JRC, 0, i[2:0], 0, s);
            v = {lk, fl[3:0]};
            rd(cpfu_pkg::OFS_PC,
               16'(v[i[2:0]] == s ? 16'h4000 + {{8{n[7]}}, n} : 16'h4000));
        end
        $display("test conditions done");
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            b = $random(seed);
            bus(1, rf(3), v);
            bus(1, cpfu_pkg::OFS_PC, 16'h8000);
            ex(cpfu_pkg::OP_RMJ, 3, b, i[2:0], 0);
            r = ((v >> b) | (v << (8 - b))) & (8'hff >> i) & 8'hfe;
            rd(cpfu_pkg::OFS_PC, 16'(16'h8000 + {{8{r[7]}}, r}));
            rd(rf(3), v);
        end
        $display("test table jump done");
        for (i = 0; i < 40; i++) begin
            fl = $random(seed);
            pc = $random(seed);
            x = $random(seed);
            r = $random(seed);
            b = $random(seed);
            s = $random(seed);
            op = i < 24 ? 11 + i % 4 : 15;
            bus(1, cpfu_pkg::OFS_FLAGS, fl);
            bus(1, cpfu_pkg::OFS_PC, pc);
            bus(1, cpfu_pkg::OFS_OPND, x);
            bus(1, rf(4), r);
            ex(op, 4, b, 0, s);
            if (op == 15 && dep == 0) unf = 1;
            else if (op == 15) begin
                {pc, e7} = stk.pop_back();
                if (s) fl = e7;
                dep--;
            end else if ((op == 11 || op == 14) && r[b] != s) pc = pc;
            else if (op != 11 && dep == 12) ovf = 1;
            else begin
                if (op != 11) stk.push_back({pc, fl});
                if (op != 11) dep++;
                pc = op == 12 ? pc + {{8{x[7]}}, x[7:0]} : x;
            end
            rd(cpfu_pkg::OFS_PC, pc);
            rd(cpfu_pkg::OFS_FLAGS, fl);
            rd(cpfu_pkg::OFS_STAT, {lk, 2'b00, unf, ovf, 4'(dep)});
            chk(8'hee, {irq_enable_out, bank_out, pc_out}, {fl[4], fl[6:5], pc});
        end
        bus(1, cpfu_pkg::OFS_STAT, 32'h0000_0030);
        rd(cpfu_pkg::OFS_STAT, {lk, 4'h0, 4'(dep)});
        $display("test calls done");
        test_done();
    end
endmodule : tb
`default_nettype wire
